// ===== dcpid_motor.sv
`timescale 1ns/100ps
// stand-in for the winding power stage and the shaft encoder
module dcpid_motor #(
   parameter int LAT = 2 // encoder reporting delay, clocks
) (
   input  wire logic                                sys_clk_i,
   input  wire logic                                resetn_i,
   input  wire logic                                pwm_i,       // winding drive
   input  wire logic                                dir_i,       // 1 = reverse
   input  wire logic                                set_i,       // load shaft position
   input  wire logic signed [dcpid_pkg::POS_W-1:0]  set_pos_i,   // position to load
   output logic signed      [dcpid_pkg::POS_W-1:0]  motor_pos_o, // encoder reading
   output logic signed      [31:0]                  drive_o      // net winding on-time
);
   import dcpid_pkg::*;
   logic signed [POS_W-1:0] shaft;      // true shaft position
   logic signed [POS_W-1:0] pipe [LAT]; // encoder delay line
   // shaft position, placed by the bench
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         shaft <= '0;
      end else if (set_i) begin
         shaft <= set_pos_i;
      end
   end
   // encoder reports late, never early
   always_ff @(posedge sys_clk_i) begin
      pipe[0] <= shaft;
      for (int i = 1; i < LAT; i++) begin
         pipe[i] <= pipe[i-1];
      end
   end
   assign motor_pos_o = pipe[LAT-1];
   // on-time of the winding, signed by drive direction
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         drive_o <= '0;
      end else if (pwm_i) begin
         drive_o <= dir_i ? drive_o - 1 : drive_o + 1;
      end
   end
endmodule

// ===== dcpid_pkg.sv
package dcpid_pkg;
   // data widths
   localparam int POS_W     = 32;             // position, counts
   localparam int GAIN_W    = 16;             // gains, 0 .. 65535
   localparam int VOLT_W    = 16;             // voltages, millivolts
   localparam int CPR_W     = 16;             // encoder counts per revolution
   localparam int INT_W     = 48;             // error integral
   localparam int ACC_W     = 80;             // control action, fixed point
   localparam int PROD_W    = 96;             // action times nominal voltage
   localparam int DIV_W     = VOLT_W + CPR_W; // supply times resolution
   localparam int FRAC_W    = 24;             // fraction bits of the action
   localparam int DUTY_FRAC = 15;             // fraction bits of the duty
   localparam int DUTY_W    = 16;             // duty width incl. full scale
   localparam int PWM_W     = 10;             // pwm carrier counter
   localparam int CNT_W     = 32;             // sample period counter
   localparam int STEP_W    = 5;              // divider step counter
   // scaling figures
   localparam longint P_FULL_REV    = 256;    // revolutions of error for full duty
   localparam longint I_FULL_MREV_S = 52500;  // 52.5 rev*s, in milli-rev*s
   localparam longint D_FULL_RPM    = 96000;  // speed excess for full duty
   // timing
   localparam longint CLK_PERIOD_NS   = 25;   // 40 MHz system clock
   localparam int     CTRL_CYCLES_DEF = 40000; // 1 ms regulator period
   // reset and full scale values
   localparam logic [DUTY_W-1:0] DUTY_FULL  = 16'h8000;
   localparam logic [DUTY_W-1:0] DUTY_RESET = 16'h0000;
   // regulator pipeline states
   typedef enum logic [2:0] {
      DCPID_IDLE, DCPID_ERR, DCPID_SUM, DCPID_MUL, DCPID_CHK, DCPID_DIV, DCPID_OUT
   } dcpid_state_t;
endpackage

// ===== dcpid_top.sv
`timescale 1ns/100ps
module dcpid_top #(
   parameter int CTRL_CYCLES = dcpid_pkg::CTRL_CYCLES_DEF // regulator period in clocks
) (
   input  wire logic                                   sys_clk_i,
   input  wire logic                                   resetn_i,
   input  wire logic        [dcpid_pkg::GAIN_W-1:0]    kp_i,
   input  wire logic        [dcpid_pkg::GAIN_W-1:0]    ki_i,
   input  wire logic        [dcpid_pkg::GAIN_W-1:0]    kd_i,
   input  wire logic signed [dcpid_pkg::POS_W-1:0]     target_i,
   input  wire logic        [dcpid_pkg::POS_W-2:0]     speed_i,
   input  wire logic                                   move_i,
   input  wire logic                                   stop_i,
   input  wire logic                                   limit_stop_i,
   input  wire logic signed [dcpid_pkg::POS_W-1:0]     motor_pos_i,
   input  wire logic        [dcpid_pkg::VOLT_W-1:0]    supply_mv_i,
   input  wire logic        [dcpid_pkg::VOLT_W-1:0]    nom_mv_i,
   input  wire logic        [dcpid_pkg::CPR_W-1:0]     encoder_counts_per_rev_i,
   output logic                                        pwm_o,
   output logic                                        dir_o,
   output logic             [dcpid_pkg::DUTY_W-1:0]    pwm_duty_cycle_o,
   output logic signed      [dcpid_pkg::POS_W-1:0]     setpoint_o,
   output logic                                        reached_o
);
   import dcpid_pkg::*;

   // term weights in 2^FRAC_W units of full duty per revolution
   localparam longint ONE  = 64'd1 << FRAC_W;
   localparam longint TS_NS = longint'(CTRL_CYCLES) * CLK_PERIOD_NS;
   localparam logic signed [ACC_W-1:0] C_P = ACC_W'(ONE / P_FULL_REV);
   localparam logic signed [ACC_W-1:0] C_I =
      ACC_W'((ONE * TS_NS + I_FULL_MREV_S * 500000) / (I_FULL_MREV_S * 1000000));
   localparam logic signed [ACC_W-1:0] C_D =
      ACC_W'((ONE * 64'd60_000_000_000) / (D_FULL_RPM * TS_NS));
   localparam int SHIFT = FRAC_W - DUTY_FRAC; // fixed point to duty units

   logic        [CNT_W-1:0]     tick_cnt;  // sample period counter
   logic                        tick;      // one cycle per regulator period
   logic signed [POS_W-1:0]     target;    // final target position
   logic signed [POS_W-1:0]     setpoint;  // running setpoint
   logic signed [POS_W:0]       gap;       // target minus setpoint
   logic signed [POS_W:0]       step;      // ramp step, signed
   logic                        reached;   // target reached flag
   dcpid_state_t                state;     // regulator pipeline state
   logic signed [POS_W-1:0]     err;       // position error
   logic signed [POS_W-1:0]     err_prev;  // previous error
   logic signed [POS_W-1:0]     derr;      // error difference
   logic signed [INT_W-1:0]     integ;     // error integral, count*samples
   logic signed [ACC_W-1:0]     acc;       // control action
   logic        [ACC_W-1:0]     mag;       // magnitude of action
   logic        [PROD_W-1:0]    rem;       // dividend, then remainder
   logic        [DIV_W-1:0]     dvs;       // divisor
   logic        [PROD_W-1:0]    dsh;       // shifted divisor
   logic        [DUTY_FRAC-1:0] quo;       // quotient
   logic        [STEP_W-1:0]    dcnt;      // divider step
   logic                        sat;       // action at or beyond full scale
   logic                        zdiv;      // divisor is zero
   logic                        neg;       // action is negative
   logic        [DUTY_W-1:0]    duty;      // clamped duty magnitude
   logic                        dir;       // drive direction
   logic        [PWM_W-1:0]     pwm_cnt;   // pwm carrier
   logic                        pwm;       // pwm level

   // sample tick generator
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else if (tick_cnt == CNT_W'(CTRL_CYCLES - 1)) begin
         tick_cnt <= '0;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
         tick     <= 1'b0;
      end
   end

   // ramp step toward target, limited by speed
   always_comb begin
      gap  = (POS_W+1)'(target) - (POS_W+1)'(setpoint);
      step = gap;
      if (gap > $signed({2'b00, speed_i})) begin
         step = $signed({2'b00, speed_i});
      end else if (-gap > $signed({2'b00, speed_i})) begin
         step = -$signed({2'b00, speed_i});
      end
   end

   // target and running setpoint
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         target   <= '0;
         setpoint <= '0;
      end else begin
         if (move_i) begin
            target <= target_i;
         end else if (stop_i || limit_stop_i) begin
            target <= setpoint;
         end
         if (tick) begin
            setpoint <= POS_W'((POS_W+1)'(setpoint) + step);
         end
      end
   end

   // sticky reached flag, cleared by a new move
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         reached <= 1'b0;
      end else if (move_i) begin
         reached <= 1'b0;
      end else if (tick && setpoint == target && motor_pos_i == target) begin
         reached <= 1'b1;
      end
   end
   // magnitude of the action
   always_comb begin
      mag = acc[ACC_W-1] ? ACC_W'(-acc) : ACC_W'(acc);
   end
   // regulator pipeline: error, terms, scaling, divide, clamp
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state    <= DCPID_IDLE;
         err      <= '0;
         err_prev <= '0;
         derr     <= '0;
         integ    <= '0;
         acc      <= '0;
         rem      <= '0;
         dvs      <= '0;
         dsh      <= '0;
         quo      <= '0;
         dcnt     <= '0;
         sat      <= 1'b0;
         zdiv     <= 1'b0;
         neg      <= 1'b0;
         duty     <= DUTY_RESET;
         dir      <= 1'b0;
      end else begin
         unique case (state)
            DCPID_IDLE: begin
               // regulation never pauses, also after a hard stop
               if (tick) begin
                  err   <= setpoint - motor_pos_i;
                  state <= DCPID_ERR;
               end
            end
            DCPID_ERR: begin
               integ    <= integ + INT_W'(err);
               derr     <= err - err_prev;
               err_prev <= err;
               state    <= DCPID_SUM;
            end
            DCPID_SUM: begin
               // unsigned gains zero-extend, error terms sign-extend
               acc <= ACC_W'(kp_i) * ACC_W'(err) * C_P
                    + ACC_W'(ki_i) * ACC_W'(integ) * C_I
                    + ACC_W'(kd_i) * ACC_W'(derr) * C_D;
               state <= DCPID_MUL;
            end
            DCPID_MUL: begin
               rem   <= (PROD_W'(mag) * PROD_W'(nom_mv_i)) >> SHIFT;
               dvs   <= DIV_W'(supply_mv_i) * DIV_W'(encoder_counts_per_rev_i);
               neg   <= acc[ACC_W-1];
               state <= DCPID_CHK;
            end
            DCPID_CHK: begin
               zdiv  <= (dvs == '0);
               sat   <= rem >= (PROD_W'(dvs) << DUTY_FRAC);
               dsh   <= PROD_W'(dvs) << (DUTY_FRAC - 1);
               quo   <= '0;
               dcnt  <= '0;
               state <= DCPID_DIV;
            end
            DCPID_DIV: begin
               // restoring division, one quotient bit a cycle
               if (rem >= dsh) begin
                  rem <= rem - dsh;
                  quo <= {quo[DUTY_FRAC-2:0], 1'b1};
               end else begin
                  quo <= {quo[DUTY_FRAC-2:0], 1'b0};
               end
               dsh  <= dsh >> 1;
               dcnt <= dcnt + 1'b1;
               if (dcnt == STEP_W'(DUTY_FRAC - 1)) begin
                  state <= DCPID_OUT;
               end
            end
            DCPID_OUT: begin
               if (zdiv) begin
                  duty <= DUTY_RESET; // no supply reading, no drive
               end else if (sat) begin
                  duty <= DUTY_FULL;
               end else begin
                  duty <= {1'b0, quo};
               end
               dir   <= neg;
               state <= DCPID_IDLE;
            end
         endcase
      end
   end
   // pwm carrier, fill factor from duty
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pwm_cnt <= '0;
         pwm     <= 1'b0;
      end else begin
         pwm_cnt <= pwm_cnt + 1'b1;
         pwm     <= {1'b0, pwm_cnt} < duty[DUTY_W-1:DUTY_W-PWM_W-1];
      end
   end
   // outputs straight from flops
   assign pwm_o            = pwm;
   assign dir_o            = dir;
   assign pwm_duty_cycle_o = duty;
   assign setpoint_o       = setpoint;
   assign reached_o        = reached;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // pipeline walk
   sequence s_head;
      state == DCPID_MUL ##1 state == DCPID_CHK ##1 state == DCPID_DIV;
   endsequence
   sequence s_tail;
      state == DCPID_OUT ##1 state == DCPID_IDLE;
   endsequence
   property p_err_form;
      state == DCPID_IDLE && tick |=> err == $past(setpoint) - $past(motor_pos_i);
   endproperty
   a_err_form: assert property (p_err_form) else $error("error not setpoint minus position");
   property p_zero_gain;
      state == DCPID_SUM && kp_i == '0 && ki_i == '0 && kd_i == '0 |=> acc == '0;
   endproperty
   a_zero_gain: assert property (p_zero_gain) else $error("action nonzero with zero gains");
   property p_p_only;
      state == DCPID_SUM && ki_i == '0 && kd_i == '0 && err == '0 |=> acc == '0;
   endproperty
   a_p_only: assert property (p_p_only) else $error("proportional term wrong");
   // non-negative terms with unsigned gains never give a negative action
   property p_gain_unsigned;
      state == DCPID_SUM && err >= 0 && integ >= 0 && derr >= 0 |=> !acc[ACC_W-1];
   endproperty
   a_gain_unsigned: assert property (p_gain_unsigned) else $error("gain taken as signed");
   // a stop on the tick edge freezes the old setpoint, so it is left out here
   property p_track;
      tick && !move_i && !stop_i && !limit_stop_i && speed_i != '0 && setpoint < target |=>
         setpoint > $past(setpoint) && setpoint <= target;
   endproperty
   a_track: assert property (p_track) else $error("setpoint not ramping to target");
   property p_walk;
      state == DCPID_SUM |=> s_head ##[14:16] s_tail;
   endproperty
   a_walk: assert property (p_walk) else $error("duty computation did not finish");
   property p_sat;
      state == DCPID_OUT && sat && !zdiv |=> duty == DUTY_FULL;
   endproperty
   a_sat: assert property (p_sat) else $error("saturated duty not full scale");
   property p_clamp;
      duty <= DUTY_FULL;
   endproperty
   a_clamp: assert property (p_clamp) else $error("duty above full scale");
   property p_dir;
      state == DCPID_OUT |=> dir == $past(neg);
   endproperty
   a_dir: assert property (p_dir) else $error("direction not from action sign");
   property p_pwm_full;
      duty == DUTY_FULL [*2] |-> pwm;
   endproperty
   a_pwm_full: assert property (p_pwm_full) else $error("full duty pwm not high");
   property p_pwm_zero;
      duty == '0 [*2] |-> !pwm;
   endproperty
   a_pwm_zero: assert property (p_pwm_zero) else $error("zero duty pwm not low");
   property p_reach_set;
      tick && !move_i && setpoint == target && motor_pos_i == target |=> reached;
   endproperty
   a_reach_set: assert property (p_reach_set) else $error("reached not set");
   property p_reach_hold;
      reached && !move_i |=> reached;
   endproperty
   a_reach_hold: assert property (p_reach_hold) else $error("reached lost without move");
   property p_stop;
      (stop_i || limit_stop_i) && !move_i |=> target == $past(setpoint);
   endproperty
   a_stop: assert property (p_stop) else $error("hard stop did not freeze target");
endmodule

// ===== dcpid_top_tb.sv
`timescale 1ns/100ps
// reference model runs beside the regulator and is compared every period
module dcpid_top_tb;
   import dcpid_pkg::*;
   localparam int     P  = 2500;                 // regulator period, clocks
   localparam longint TS = P * CLK_PERIOD_NS;    // period in ns
   localparam longint X  = 64'hc393e6d00;        // 52.5 s in ns
   localparam longint CI = ((TS <<< 25) + X) / (2 * X);  // rounded integral weight
   localparam longint CD = (64'h98968 <<< 24) / TS;      // derivative weight
   logic sys_clk = 0, resetn = 0, move = 0, stop = 0, lstop = 0, set = 0;
   logic [15:0] kp = 0, ki = 0, kd = 0, supply = 0, nom = 0, cpr = 0;
   logic signed [31:0] target = 0, set_pos = 0, motor_pos, setpoint, drive;
   logic [30:0] speed = 0;
   logic pwm, dir, reached;
   logic [15:0] duty;
   logic signed [127:0] sp = 0, tgt = 0, integ = 0, eprev = 0, pos = 0, dvs;
   logic [15:0] m_duty;
   logic m_dir, m_reach = 0;
   int cyc = 0, k = 0, n_fail = 0, n_tests = 0;
   dcpid_top #(.CTRL_CYCLES(P)) dut (.sys_clk_i(sys_clk), .resetn_i(resetn), .kp_i(kp),
      .ki_i(ki), .kd_i(kd), .target_i(target), .speed_i(speed), .move_i(move), .stop_i(stop),
      .limit_stop_i(lstop), .motor_pos_i(motor_pos), .supply_mv_i(supply), .nom_mv_i(nom),
      .encoder_counts_per_rev_i(cpr), .pwm_o(pwm), .dir_o(dir), .pwm_duty_cycle_o(duty),
      .setpoint_o(setpoint), .reached_o(reached));
   dcpid_motor motor (.sys_clk_i(sys_clk), .resetn_i(resetn), .pwm_i(pwm), .dir_i(dir),
      .set_i(set), .set_pos_i(set_pos), .motor_pos_o(motor_pos), .drive_o(drive));
   // 40 MHz clock
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // clocks since reset release
   always @(posedge sys_clk) begin
      cyc <= resetn ? cyc + 1 : 0;
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   task automatic wait_cyc(input int t);
      while (cyc < t) begin
         @(posedge sys_clk);
         #1;
      end
   endtask
   // one regulator tick of the model
   task automatic step();
      logic signed [127:0] d, lim, err, acc, rem;
      err = sp - pos;
      if (sp == tgt && pos == tgt) m_reach = 1'b1;
      lim = speed;
      d = tgt - sp;
      if (d > lim) d = lim;
      else if (d < -lim) d = -lim;
      sp = sp + d;
      integ = integ + err;
      acc = $signed({1'b0, kp}) * err * 65536 + $signed({1'b0, ki}) * integ * CI
          + $signed({1'b0, kd}) * (err - eprev) * CD;
      eprev = err;
      m_dir = acc < 0;
      rem = ((acc < 0 ? -acc : acc) * nom) >>> 9;
      dvs = supply * cpr;
      if (dvs == 0) m_duty = '0;
      else if (rem >= (dvs <<< 15)) m_duty = DUTY_FULL;
      else m_duty = rem / dvs;
   endtask
   // run to mid-period after the next tick and compare everything but direction while dvs is zero
   task automatic period();
      logic signed [31:0] d0;
      step();
      k++;
      wait_cyc(k * P + 100);
      d0 = drive;
      wait_cyc(k * P + 1124);
      d0 = drive - d0;
      wait_cyc(k * P + 1250);
      check(duty, m_duty, "duty");
      check(d0 < 0 ? -d0 : d0, m_duty >> 5, "pwm on-time");
      if (dvs != 0) check(dir, m_dir, "direction");
      check(setpoint, sp, "setpoint");
      check(reached, m_reach, "reached");
   endtask
   task automatic go(input logic signed [31:0] t);
      target = t;
      move = 1;
      @(posedge sys_clk);
      #1;
      move = 0;
      tgt = t;
      m_reach = 0;
   endtask
   task automatic halt(input bit lim);
      stop = !lim;
      lstop = lim;
      @(posedge sys_clk);
      #1;
      stop = 0;
      lstop = 0;
      tgt = sp;
   endtask
   task automatic place(input logic signed [31:0] p);
      set = 1;
      set_pos = p;
      @(posedge sys_clk);
      #1;
      set = 0;
      pos = p;
   endtask
   // hang guard
   initial begin
      #(longint'(P) * 25 * 36);
      n_fail++;
      summarize();
   end
   initial begin
      void'($urandom(32'hde89));
      repeat (5) @(posedge sys_clk);
      #1;
      resetn = 1;
      kp = 16'h0001;
      nom = 16'h2ee0;
      supply = 16'h2ee0;
      cpr = 16'h0004;
      speed = 31'h0010_0000;
      go(1024);
      period();
      period();  // 256 revolutions gives exactly full duty
      go(1023);
      period();
      period();
      // random gains over the full range, random supply and resolution
      repeat (18) begin
         kp = 16'($urandom_range(0, 65535) >> (4 * $urandom_range(0, 3)));
         ki = 16'($urandom_range(0, 65535) >> (4 * $urandom_range(0, 3)));
         kd = 16'($urandom_range(0, 65535) >> (4 * $urandom_range(0, 3)));
         supply = 16'($urandom_range(6000, 48000));
         nom = 16'($urandom_range(1, 24000));
         cpr = 16'($urandom_range(1, 4096));
         place(32'(sp + $urandom_range(0, 8191) - 4096));
         if ($urandom_range(0, 3) == 0) begin
            speed = 31'($urandom_range(1, 40000));
            go(32'($urandom_range(0, 131071) - 65536));
         end
         if ($urandom_range(0, 5) == 0) halt(1'($urandom_range(0, 1)));
         period();
      end
      // reached sticks through later wobble, cleared by a new move
      kp = 16'h0040;
      speed = 31'h0010_0000;
      go(2000);
      place(2000);
      period();
      period();
      place(2003);
      period();
      go(2000);
      period();
      // hard stops freeze the setpoint, regulation continues both ways
      speed = 31'd50;
      go(-100000);
      period();
      halt(0);
      place(32'(sp - 40));
      period();
      period();
      go(100000);
      period();
      halt(1);
      place(32'(sp + 40));
      period();
      // no supply reading gives zero duty
      supply = 16'h0000;
      period();
      // zero gains give no action whatever the error
      supply = 16'h2ee0;
      kp = 16'h0000;
      ki = 16'h0000;
      kd = 16'h0000;
      period();
      summarize();
   end
endmodule
